/* hdl/pcfc_pkg.sv */
// shared constants and types for the pll configuration and feed control
package pcfc_pkg;

   // apb data path
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;

   // device register byte addresses
   localparam logic [ADDR_W-1:0] CON_ADDR  = 32'he01fc080;
   localparam logic [ADDR_W-1:0] CFG_ADDR  = 32'he01fc084;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 32'he01fc088;
   localparam logic [ADDR_W-1:0] FEED_ADDR = 32'he01fc08c;

   // field layout
   localparam int MULT_SELECT_LSB = 0;
   localparam int MULT_SELECT_W   = 5;
   localparam int PSEL_LSB   = 5;
   localparam int PSEL_W     = 2;
   localparam int CFG_W      = 7;
   localparam int CON_W      = 2;
   localparam int CON_EN_BIT = 0;
   localparam int CON_CN_BIT = 1;
   localparam int STAT_W     = 16;
   localparam int ST_EN_BIT  = 8;
   localparam int ST_CN_BIT  = 9;
   localparam int ST_LK_BIT  = 10;
   localparam int FEED_W     = 8;
   localparam int MULT_W     = 6;
   localparam int DIVP_W     = 4;

   // reset values and feed keys
   localparam logic [CFG_W-1:0]  CFG_RST   = 7'h00;
   localparam logic [CON_W-1:0]  CON_RST   = 2'h0;
   localparam logic [FEED_W-1:0] FEED_KEY1 = 8'haa;
   localparam logic [FEED_W-1:0] FEED_KEY2 = 8'h55;
   localparam logic [MULT_W-1:0] MULT_ONE  = 6'h01;
   localparam logic [DIVP_W-1:0] DIVP_ONE  = 4'h1;

   // gap count; both clock gates stay shut for one cycle more than this during a source change
   localparam int SWITCH_GAP = 4;

   // controller command port map
   localparam logic [1:0] HREG_ADDR  = 2'h0;
   localparam logic [1:0] HREG_WDATA = 2'h1;
   localparam logic [1:0] HREG_CMD   = 2'h2;
   localparam logic [1:0] HREG_STAT  = 2'h3;
   localparam int CMD_WR_BIT   = 0;
   localparam int CMD_RD_BIT   = 1;
   localparam int CMD_FEED_BIT = 2;
   localparam int HST_BUSY_BIT = 0;
   localparam int HST_RD_LSB   = 16;

   typedef enum logic [1:0] {
      SW_OSC     = 2'b00,
      SW_TO_PLL  = 2'b01,
      SW_PLL     = 2'b10,
      SW_TO_OSC  = 2'b11
   } pcfc_sw_state_t;

   typedef enum logic [1:0] {
      AP_IDLE    = 2'b00,
      AP_SETUP   = 2'b01,
      AP_ACCESS  = 2'b10
   } pcfc_apb_state_t;

endpackage : pcfc_pkg

/* hdl/pcfc_if.sv */
// apb link between the register controller and the pll control block
`timescale 1ns/10ps
interface pcfc_if;
   import pcfc_pkg::*;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;

   modport dev (
      input  psel,
      input  penable,
      input  pwrite,
      input  paddr,
      input  pwdata,
      output prdata,
      output pready
   );

   modport host (
      output psel,
      output penable,
      output pwrite,
      output paddr,
      output pwdata,
      input  prdata,
      input  pready
   );
endinterface : pcfc_if

/* hdl/pcfc_src_switch.sv */
// break-before-make sequencer for the core clock source gates
`timescale 1ns/10ps
module pcfc_src_switch #(
   parameter int GAP = pcfc_pkg::SWITCH_GAP
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic want_pll,
   output logic      osc_en,
   output logic      pll_en
);
   import pcfc_pkg::*;

   localparam int CW = $clog2(GAP + 1);
   localparam logic [CW-1:0] GAP_C = CW'(GAP);

   pcfc_sw_state_t st_q;
   pcfc_sw_state_t st_d;
   logic [CW-1:0]  cnt_q;
   logic [CW-1:0]  cnt_d;
   logic           gap_done;

   // both gates stay shut for the gap, so no runt pulse on core clock
   assign gap_done = (cnt_q == GAP_C);

   always_comb begin
      st_d  = st_q;
      cnt_d = '0;
      unique case (st_q)
         SW_OSC: if (want_pll) st_d = SW_TO_PLL;
         SW_TO_PLL: begin
            cnt_d = cnt_q + 1'b1;
            if (!want_pll) st_d = SW_TO_OSC;
            else if (gap_done) st_d = SW_PLL;
         end
         SW_PLL: if (!want_pll) st_d = SW_TO_OSC;
         SW_TO_OSC: begin
            cnt_d = cnt_q + 1'b1;
            if (gap_done) st_d = SW_OSC;
         end
      endcase
      if (st_d != st_q) cnt_d = '0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q   <= SW_OSC;
         cnt_q  <= '0;
         osc_en <= 1'b1;
         pll_en <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         osc_en <= (st_d == SW_OSC);
         pll_en <= (st_d == SW_PLL);
      end
   end
endmodule : pcfc_src_switch

/* hdl/pcfc_dev.sv */
// pll control block: staged registers, feed commit, status, clock select
// What this block does
// - config writes staged until valid feed
// - bits 4:0 hold multiplier minus one
// - bits 6:5 select divider 1,2,4,8
// - status bits 6:0 show applied multiplier and divider
// - status bit 8 applied enable, cleared powerdown
// - status bit 9 applied connect, cleared powerdown
// - status bit 10 shows pll lock
// - lock drives interrupt request output
// - pll clock only when enable and connect
// - feed aa then 55; else discard
// - feed writes must be consecutive transfers; only a feed read may come between
// - software masks interrupts during feed
// - powerdown turns pll off, no restore
// - after wake enable, await lock, connect
// - core clock m times oscillator frequency
// - software keeps input and oscillator ranges
// - software writes zero to reserved bits
// - control bit0 enable, bit1 connect, staged
// - source change is glitch free
`timescale 1ns/10ps
module pcfc_dev (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   pcfc_if.dev                                bus,
   input  wire logic                          lock_detect_raw,
   input  wire logic                          pd_enter,
   output logic                               pll_power_en,
   output logic [pcfc_pkg::MULT_SELECT_W-1:0] pll_mult_select,
   output logic [pcfc_pkg::PSEL_W-1:0]        pll_psel,
   output logic [pcfc_pkg::MULT_W-1:0]        pll_mult_m,
   output logic [pcfc_pkg::DIVP_W-1:0]        pll_div_p,
   output logic                               osc_clk_en,
   output logic                               pll_clk_en,
   output logic                               lock_irq
);
   import pcfc_pkg::*;

   // lock detector synchroniser
   logic              lock_s1_q;
   logic              lock_s2_q;

   // staging and applied copies
   logic [CON_W-1:0]  con_stg_q;
   logic [CON_W-1:0]  con_stg_d;
   logic [CFG_W-1:0]  cfg_stg_q;
   logic [CFG_W-1:0]  cfg_stg_d;
   logic              en_q;
   logic              en_d;
   logic              cn_q;
   logic              cn_d;
   logic [CFG_W-1:0]  cfg_app_q;
   logic [CFG_W-1:0]  cfg_app_d;
   logic              armed_q;
   logic              armed_d;

   // bus side
   logic [DATA_W-1:0] prdata_q;
   logic              pready_q;
   logic [DATA_W-1:0] rdata_d;
   logic              irq_q;
   logic [MULT_W-1:0] mult_q;
   logic [DIVP_W-1:0] divp_q;

   // decode
   wire               setup;
   wire               xfer;
   wire               wr_done;
   wire               hit_con;
   wire               hit_cfg;
   wire               hit_stat;
   wire               hit_feed;
   wire               feed_wr;
   wire               feed_rd;
   wire               key1;
   wire               key2;
   wire               commit;
   wire               discard;
   wire               lock_now;
   wire [STAT_W-1:0]  stat_word;
   wire               want_pll;
   wire [FEED_W-1:0]  feed_val;

   assign setup    = bus.psel & ~bus.penable;
   assign xfer     = bus.psel & bus.penable & pready_q;
   assign wr_done  = xfer & bus.pwrite;
   assign hit_con  = (bus.paddr == CON_ADDR);
   assign hit_cfg  = (bus.paddr == CFG_ADDR);
   assign hit_stat = (bus.paddr == STAT_ADDR);
   assign hit_feed = (bus.paddr == FEED_ADDR);
   assign feed_val = bus.pwdata[FEED_W-1:0];
   assign feed_wr  = wr_done & hit_feed;
   assign feed_rd  = xfer & ~bus.pwrite & hit_feed;
   assign key1     = (feed_val == FEED_KEY1);
   assign key2     = (feed_val == FEED_KEY2);

   // second key counts only right after the first, with no transfer between other than a feed read
   assign commit   = feed_wr & key2 & armed_q;
   // any other feed value throws the staged changes away
   assign discard  = feed_wr & ~key1 & ~commit;

   // lock is meaningless while the pll is powered off
   assign lock_now = lock_s2_q & en_q;

   // reserved status bits read as zero
   assign stat_word = {
      {(STAT_W-ST_LK_BIT-1){1'b0}},
      lock_now,
      cn_q,
      en_q,
      {(ST_EN_BIT-CFG_W){1'b0}},
      cfg_app_q
   };

   // pll only when both applied bits are set
   assign want_pll = en_q & cn_q;

   // arm on first key; any other completed transfer except a feed read disarms
   always_comb begin
      armed_d = armed_q;
      if (feed_wr)
         armed_d = key1;
      else if (xfer && !feed_rd)
         armed_d = 1'b0;
   end

   // staging copies take bus writes; discard reloads them
   always_comb begin
      con_stg_d = con_stg_q;
      cfg_stg_d = cfg_stg_q;
      if (discard) begin
         con_stg_d = {cn_q, en_q};
         cfg_stg_d = cfg_app_q;
      end else if (wr_done && hit_con) begin
         con_stg_d = bus.pwdata[CON_W-1:0];
      end else if (wr_done && hit_cfg) begin
         cfg_stg_d = bus.pwdata[CFG_W-1:0];
      end
   end

   // applied copies change on commit; power-down clears enable and connect and beats commit for them
   always_comb begin
      en_d      = en_q;
      cn_d      = cn_q;
      cfg_app_d = cfg_app_q;
      if (commit) begin
         en_d      = con_stg_q[CON_EN_BIT];
         cn_d      = con_stg_q[CON_CN_BIT];
         cfg_app_d = cfg_stg_q;
      end
      if (pd_enter) begin
         en_d = 1'b0;
         cn_d = 1'b0;
      end
   end

   // read mux; status is write-only-ignored, feed reads zero
   always_comb begin
      rdata_d = '0;
      if (hit_con)
         rdata_d = {{(DATA_W-CON_W){1'b0}}, con_stg_q};
      else if (hit_cfg)
         rdata_d = {{(DATA_W-CFG_W){1'b0}}, cfg_stg_q};
      else if (hit_stat)
         rdata_d = {{(DATA_W-STAT_W){1'b0}}, stat_word};
      else if (hit_feed)
         rdata_d = '0;
   end

   // first flop feeds only the second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lock_s1_q <= 1'b0;
         lock_s2_q <= 1'b0;
      end else begin
         lock_s1_q <= lock_detect_raw;
         lock_s2_q <= lock_s1_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         con_stg_q <= CON_RST;
         cfg_stg_q <= CFG_RST;
         en_q      <= 1'b0;
         cn_q      <= 1'b0;
         cfg_app_q <= CFG_RST;
         armed_q   <= 1'b0;
      end else begin
         con_stg_q <= con_stg_d;
         cfg_stg_q <= cfg_stg_d;
         en_q      <= en_d;
         cn_q      <= cn_d;
         cfg_app_q <= cfg_app_d;
         armed_q   <= armed_d;
      end
   end

   // read data captured in setup phase, shown in the access phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_q <= '0;
         pready_q <= 1'b0;
      end else begin
         prdata_q <= (setup && !bus.pwrite) ? rdata_d : '0;
         pready_q <= 1'b1;
      end
   end

   // decoded m and p travel with the applied fields
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_q  <= 1'b0;
         mult_q <= MULT_ONE;
         divp_q <= DIVP_ONE;
      end else begin
         irq_q  <= lock_now;
         mult_q <= MULT_W'(cfg_app_d[MULT_SELECT_LSB +: MULT_SELECT_W])
                   + MULT_ONE;
         divp_q <= DIVP_ONE << cfg_app_d[PSEL_LSB +: PSEL_W];
      end
   end

   pcfc_src_switch #(
      .GAP      (SWITCH_GAP)
   ) u_switch (
      .clk      (clk),
      .rst_n    (rst_n),
      .want_pll (want_pll),
      .osc_en   (osc_clk_en),
      .pll_en   (pll_clk_en)
   );

   assign bus.prdata = prdata_q;
   assign bus.pready = pready_q;
   assign pll_power_en = en_q;
   assign pll_mult_select = cfg_app_q[MULT_SELECT_LSB +: MULT_SELECT_W];
   assign pll_psel   = cfg_app_q[PSEL_LSB +: PSEL_W];
   assign pll_mult_m = mult_q;
   assign pll_div_p  = divp_q;
   assign lock_irq   = irq_q;

endmodule : pcfc_dev

/* hdl/pcfc_host.sv */
// register controller: software command port to apb master
`timescale 1ns/10ps
module pcfc_host (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   pcfc_if.host                             bus,
   input  wire logic [1:0]                  cmd_addr,
   input  wire logic [pcfc_pkg::DATA_W-1:0] cmd_wdata,
   input  wire logic                        cmd_wr,
   input  wire logic                        cmd_rd,
   output logic [pcfc_pkg::DATA_W-1:0]      cmd_rdata
);
   import pcfc_pkg::*;

   pcfc_apb_state_t   st_q;
   logic [ADDR_W-1:0] tgt_q;
   logic [FEED_W-1:0] wd_q;
   logic [STAT_W-1:0] last_q;
   logic              feed2_q;
   logic              psel_q;
   logic              pen_q;
   logic              pwr_q;
   logic [ADDR_W-1:0] paddr_q;
   logic [FEED_W-1:0] pwd_q;
   logic [DATA_W-1:0] rdata_q;

   wire               idle;
   wire               cmd_go;
   wire               go_feed;
   wire               go_wr;
   wire               go_rd;
   wire               acc_done;
   wire [DATA_W-1:0]  stat_word;
   wire [DATA_W-1:0]  rd_mux;

   assign idle     = (st_q == AP_IDLE);
   assign cmd_go   = cmd_wr & (cmd_addr == HREG_CMD) & idle;
   assign go_feed  = cmd_go & cmd_wdata[CMD_FEED_BIT];
   assign go_wr    = cmd_go & cmd_wdata[CMD_WR_BIT] & ~go_feed;
   assign go_rd    = cmd_go & cmd_wdata[CMD_RD_BIT] & ~go_feed & ~go_wr;
   assign acc_done = (st_q == AP_ACCESS) & bus.pready;
   assign stat_word = {last_q, {(HST_RD_LSB-1){1'b0}}, ~idle};
   assign rd_mux   = (cmd_addr == HREG_ADDR)  ? tgt_q :
                     (cmd_addr == HREG_WDATA) ?
                        {{(DATA_W-FEED_W){1'b0}}, wd_q} :
                     (cmd_addr == HREG_STAT)  ? stat_word : '0;

   // command registers; write data keeps only bits 7:0, so bits 31:8 never leave as ones
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tgt_q   <= '0;
         wd_q    <= '0;
         rdata_q <= '0;
      end else begin
         if (cmd_wr && cmd_addr == HREG_ADDR) tgt_q <= cmd_wdata;
         if (cmd_wr && cmd_addr == HREG_WDATA)
            wd_q <= cmd_wdata[FEED_W-1:0];
         rdata_q <= cmd_rd ? rd_mux : '0;
      end
   end

   // feed pair goes out back to back with nothing in between
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q    <= AP_IDLE;
         feed2_q <= 1'b0;
         psel_q  <= 1'b0;
         pen_q   <= 1'b0;
         pwr_q   <= 1'b0;
         paddr_q <= '0;
         pwd_q   <= '0;
         last_q  <= '0;
      end else begin
         unique case (st_q)
            AP_IDLE: begin
               if (go_feed || go_wr || go_rd) begin
                  st_q    <= AP_SETUP;
                  psel_q  <= 1'b1;
                  pwr_q   <= ~go_rd;
                  paddr_q <= go_feed ? FEED_ADDR : tgt_q;
                  pwd_q   <= go_feed ? FEED_KEY1 : wd_q;
                  feed2_q <= go_feed;
               end
            end
            AP_SETUP: begin
               st_q  <= AP_ACCESS;
               pen_q <= 1'b1;
            end
            AP_ACCESS: begin
               if (acc_done) begin
                  pen_q <= 1'b0;
                  if (!pwr_q) last_q <= bus.prdata[STAT_W-1:0];
                  if (feed2_q) begin
                     st_q    <= AP_SETUP;
                     pwd_q   <= FEED_KEY2;
                     feed2_q <= 1'b0;
                  end else begin
                     st_q   <= AP_IDLE;
                     psel_q <= 1'b0;
                  end
               end
            end
            default: st_q <= AP_IDLE;
         endcase
      end
   end

   assign bus.psel    = psel_q;
   assign bus.penable = pen_q;
   assign bus.pwrite  = pwr_q;
   assign bus.paddr   = paddr_q;
   assign bus.pwdata  = {{(DATA_W-FEED_W){1'b0}}, pwd_q};
   assign cmd_rdata   = rdata_q;

endmodule : pcfc_host

/* verif/pcfc_properties.sv */
// assertions on the apb link and the pll control outputs
`timescale 1ns/10ps
module pcfc_properties (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pd_enter,
   input wire logic        pll_power_en,
   input wire logic [4:0]  pll_mult_select,
   input wire logic [1:0]  pll_psel,
   input wire logic [5:0]  pll_mult_m,
   input wire logic [3:0]  pll_div_p,
   input wire logic        osc_clk_en,
   input wire logic        pll_clk_en,
   input wire logic        lock_irq
);
   import pcfc_pkg::*;
   logic armed_q;
   logic armed_d;
   wire  xfer    = psel & penable & pready;
   wire  at_feed = paddr == FEED_ADDR;
   wire  feed_rd = xfer & !pwrite & at_feed;
   wire  stat_rd = xfer & !pwrite & (paddr == STAT_ADDR);
   wire  key1    = pwdata[7:0] == FEED_KEY1;
   wire  commit  = xfer & pwrite & at_feed & armed_q
                   & (pwdata[7:0] == FEED_KEY2);
   // a feed read leaves the arm state alone
   assign armed_d = (xfer & !feed_rd) ? (pwrite & at_feed & key1) : armed_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_map;
      pll_mult_m == pll_mult_select + 6'h01
         && pll_div_p == 4'h1 << pll_psel;
   endproperty
   a_map: assert property (p_map)
      else $error("multiplier or divider decode wrong");
   property p_excl;
      !(osc_clk_en && pll_clk_en);
   endproperty
   a_excl: assert property (p_excl)
      else $error("both clock gates open");
   property p_gap;
      $rose(pll_clk_en) |-> !$past(osc_clk_en, 1) && !$past(osc_clk_en, 4);
   endproperty
   a_gap: assert property (p_gap)
      else $error("pll gate opened without dead cycles");
   property p_no_silent;
      $changed(pll_mult_select) || $changed(pll_psel) || $rose(pll_power_en)
         |-> $past(commit);
   endproperty
   a_no_silent: assert property (p_no_silent)
      else $error("applied setting changed without a feed");
   property p_pd_off;
      pd_enter |=> !pll_power_en ##[0:12] (osc_clk_en && !pll_clk_en);
   endproperty
   a_pd_off: assert property (p_pd_off)
      else $error("power-down left the pll on");
   property p_irq_en;
      lock_irq |-> $past(pll_power_en);
   endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("lock request while disabled");
   property p_stat_rd;
      stat_rd |-> prdata[6:0] == {pll_psel, pll_mult_select}
                  && prdata[8] == pll_power_en;
   endproperty
   a_stat_rd: assert property (p_stat_rd)
      else $error("status read differs from applied state");
   property p_feed_rd;
      feed_rd |-> prdata == 32'h0;
   endproperty
   a_feed_rd: assert property (p_feed_rd)
      else $error("feed read not zero");
   c_commit: cover property (commit);
   c_pd: cover property (pd_enter && pll_power_en);
   c_pll: cover property ($rose(pll_clk_en));
endmodule : pcfc_properties

/* verif/pcfc_tb.sv */
// self-checking bench: host and device joined over the apb link
`timescale 1ns/10ps
module pcfc_tb;
   import pcfc_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n;
   logic [1:0]  cmd_addr;
   logic [31:0] cmd_wdata;
   logic        cmd_wr;
   logic        cmd_rd;
   logic [31:0] cmd_rdata;
   logic        lock_detect_raw;
   logic        pd_enter;
   logic        pll_power_en;
   logic [4:0]  pll_mult_select;
   logic [1:0]  pll_psel;
   logic [5:0]  pll_mult_m;
   logic [3:0]  pll_div_p;
   logic        osc_clk_en;
   logic        pll_clk_en;
   logic        lock_irq;
   int          mismatches = 0;
   int          cmp_count = 0;
   int          seed = 32'h0104;
   logic [6:0]  cf;
   logic [6:0]  ap_cf;
   logic [1:0]  cn;
   logic [1:0]  ap_cn;
   logic [15:0] v;
   logic [7:0]  bad;
   logic        lk;
   int          mode;
   pcfc_if link ();
   always #5 clk = ~clk;
   pcfc_host i_pcfc_host (.clk(clk), .rst_n(rst_n), .bus(link.host),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
   pcfc_dev i_pcfc_dev (.clk(clk), .rst_n(rst_n), .bus(link.dev),
      .lock_detect_raw(lock_detect_raw), .pd_enter(pd_enter),
      .pll_power_en(pll_power_en), .pll_mult_select(pll_mult_select),
      .pll_psel(pll_psel), .pll_mult_m(pll_mult_m), .pll_div_p(pll_div_p),
      .osc_clk_en(osc_clk_en), .pll_clk_en(pll_clk_en),
      .lock_irq(lock_irq));
   pcfc_properties i_pcfc_properties (.clk(clk), .rst_n(rst_n),
      .psel(link.psel), .penable(link.penable), .pwrite(link.pwrite),
      .paddr(link.paddr), .pwdata(link.pwdata), .prdata(link.prdata),
      .pready(link.pready), .pd_enter(pd_enter),
      .pll_power_en(pll_power_en), .pll_mult_select(pll_mult_select),
      .pll_psel(pll_psel), .pll_mult_m(pll_mult_m), .pll_div_p(pll_div_p),
      .osc_clk_en(osc_clk_en), .pll_clk_en(pll_clk_en),
      .lock_irq(lock_irq));
   task automatic results;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cwr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge clk);
      cmd_wr <= 1'b0;
   endtask : cwr
   task automatic crd(input logic [1:0] a, output logic [31:0] d);
      @(posedge clk);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge clk);
      cmd_rd <= 1'b0;
      @(negedge clk);
      d = cmd_rdata;
   endtask : crd
   // one host command through the host, two apb transfers for a feed; busy polling is bounded
   task automatic apb(input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] c);
      logic [31:0] st;
      cwr(HREG_ADDR, a);
      cwr(HREG_WDATA, d);
      cwr(HREG_CMD, c);
      for (int n = 0; n < 40; n++) begin
         crd(HREG_STAT, st);
         if (st[HST_BUSY_BIT] === 1'b0) return;
      end
      mismatches++;
      results();
   endtask : apb
   task automatic devrd(input logic [31:0] a, output logic [15:0] r);
      logic [31:0] st;
      apb(a, 32'h0, 32'h2);
      crd(HREG_STAT, st);
      r = st[31:16];
   endtask : devrd
   // power, fields, m = code plus one, p = two to the code
   function automatic logic [17:0] outs(input logic [6:0] f,
                                        input logic [1:0] c);
      return {c[0], f[4:0], f[6:5], 6'(f[4:0]) + 6'h01, 4'h1 << f[6:5]};
   endfunction : outs
   initial begin
      rst_n = 1'b0;
      cmd_addr = 2'h0;
      cmd_wdata = 32'h0;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      lock_detect_raw = 1'b0;
      pd_enter = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      ap_cf = CFG_RST;
      ap_cn = CON_RST;
      devrd(STAT_ADDR, v);
      chk(v, 32'h0);
      chk({pll_power_en, pll_mult_select, pll_psel, pll_mult_m,
          pll_div_p}, outs(ap_cf, ap_cn));
      for (int i = 0; i < 14; i++) begin
         cf = $random(seed);
         cn = $random(seed);
         lk = $random(seed);
         // rounds 4 and 5 force a bad key and a split pair
         mode = (i < 4) ? 0 : (i < 6) ? i - 3 : {$random(seed)} % 3;
         // first rounds walk every divider code and enable/connect pair
         if (i < 4) cf[6:5] = i[1:0];
         if (i < 4) cn = i[1:0] ^ 2'b10;
         if (i == 0) cf[4:0] = 5'h1f;
         @(posedge clk);
         lock_detect_raw <= lk;
         apb(CON_ADDR, {30'h0, cn}, 32'h1);
         apb(CFG_ADDR, {25'h0, cf}, 32'h1);
         devrd(CFG_ADDR, v);
         chk(v, {9'h0, cf});
         devrd(STAT_ADDR, v);
         chk(v[9:0], {ap_cn, 1'b0, ap_cf});
         if (mode == 1) begin
            bad = $random(seed);
            if (bad == FEED_KEY1) bad = 8'h12;
            apb(FEED_ADDR, {24'h0, bad}, 32'h1);
         end else if (mode == 2) begin
            apb(FEED_ADDR, {24'h0, FEED_KEY1}, 32'h1);
            devrd(CON_ADDR, v);
            apb(FEED_ADDR, {24'h0, FEED_KEY2}, 32'h1);
         end
         if (mode != 2) apb(FEED_ADDR, 32'h0, 32'h4);
         if (mode == 0) begin
            ap_cf = cf;
            ap_cn = cn;
         end
         devrd(STAT_ADDR, v);
         chk(v[9:0], {ap_cn, 1'b0, ap_cf});
         chk(v[10], lk & ap_cn[0]);
         chk(lock_irq, lk & ap_cn[0]);
         chk({pll_power_en, pll_mult_select, pll_psel, pll_mult_m,
             pll_div_p}, outs(ap_cf, ap_cn));
         chk({osc_clk_en, pll_clk_en}, &ap_cn ? 2'b01 : 2'b10);
      end
      apb(CON_ADDR, 32'h3, 32'h1);
      apb(FEED_ADDR, 32'h0, 32'h4);
      devrd(STAT_ADDR, v);
      @(posedge clk);
      lock_detect_raw <= 1'b1;
      pd_enter <= 1'b1;
      @(posedge clk);
      pd_enter <= 1'b0;
      devrd(STAT_ADDR, v);
      chk(v, {9'h0, ap_cf});
      chk({osc_clk_en, pll_clk_en, pll_power_en, lock_irq}, 4'h8);
      apb(STAT_ADDR, 32'h3ff, 32'h1);
      devrd(STAT_ADDR, v);
      chk(v, {9'h0, ap_cf});
      devrd(FEED_ADDR, v);
      chk(v, 32'h0);
      devrd(32'he01fc090, v);
      chk(v, 32'h0);
      // wake-up: enable, await lock, only then connect
      // m 6, p 2 keeps a 10 MHz input's loop at 240 MHz
      apb(CFG_ADDR, 32'h25, 32'h1);
      apb(CON_ADDR, 32'h1, 32'h1);
      apb(FEED_ADDR, 32'h0, 32'h4);
      devrd(STAT_ADDR, v);
      chk(v[10:0], 11'h525);
      chk({pll_mult_m, pll_div_p}, 10'h062);
      apb(CON_ADDR, 32'h3, 32'h1);
      apb(FEED_ADDR, 32'h0, 32'h4);
      devrd(STAT_ADDR, v);
      chk({v[10:8], osc_clk_en, pll_clk_en}, 5'h1d);
      results();
   end
endmodule : pcfc_tb
